// *** inc/ipc_params.svh ***
// constants for the interrupt priority control block
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH

// ------------------------------------------------------------
// register indices on the plain register port
// ------------------------------------------------------------
`define IPC_ADDR_W 4
`define IPC_A_IRQ2 4'h0
`define IPC_A_SERR 4'h1
`define IPC_A_PEND 4'h2
`define IPC_A_CTRL 4'h3
`define IPC_A_FLAG 4'h4
`define IPC_A_EN 4'h5
`define IPC_A_STAT 4'h6

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define IPC_PRIO_LSB 4
`define IPC_PRIO_MSB 6
`define IPC_NEST_BIT 15
`define IPC_TRAP_LSB 1
`define IPC_TRAP_MSB 4
`define IPC_ILR_LSB 8
`define IPC_ILR_MSB 11
`define IPC_SRL_LVL_LSB 5
`define IPC_IPL3_BIT 8

// ------------------------------------------------------------
// reset values and fixed codes
// ------------------------------------------------------------
`define IPC_PRIO_RST 3'h4
`define IPC_SRL_RST 8'h00
`define IPC_VEC_BASE 8'h08
`define IPC_VEC_IRQ2 8'h25
`define IPC_VEC_SERR 8'h49
`define IPC_VEC_TRAP0 8'h02
`define IPC_TRAP_LVL_TOP 4'he
`define IPC_USER_MAX 4'h7
`define IPC_TIMED_IRQ_DISABLE_TOP 3'h6
`define IPC_STACK_DEPTH 4
`define IPC_NUM_TRAP 4
`define IPC_NUM_CAND 6

`endif

// *** inc/ipc_pkg.sv ***
// types shared by the interrupt priority control block
package ipc_pkg;

    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ipc_bus_type;

    // request offered to the core
    typedef struct packed {
        logic req;
        logic [7:0] vector;
        logic [3:0] level;
    } ipc_irq_type;

    // one arbitration candidate, level 0 means not requesting
    typedef struct packed {
        logic [3:0] level;
        logic [7:0] vector;
    } ipc_cand_type;

endpackage

// *** hw/ipc_pick.sv ***
// highest-level, lowest-vector selection among candidates
`timescale 1ns/1ps

module ipc_pick #(
    parameter int N = 6
) (
    // candidates
    input ipc_pkg::ipc_cand_type cand_i [N],
    // winner
    output ipc_pkg::ipc_cand_type win_o
);
    import ipc_pkg::*;

    // linear scan; on equal level the lower vector is kept
    always_comb begin
        win_o = '0;
        for (int i = 0; i < N; i++) begin
            if (cand_i[i].level > win_o.level) begin
                win_o = cand_i[i];
            end else if (cand_i[i].level != 4'h0 && cand_i[i].level == win_o.level &&
                         cand_i[i].vector < win_o.vector) begin
                win_o = cand_i[i]; // RULE_17
            end
        end
    end

endmodule // ipc_pick

// *** hw/ipc_top.sv ***
// interrupt priority control: priorities, masking, nesting, status
// Notes on behaviour
// [RULE_01] ext irq2 priority at bits 6:4
// [RULE_02] serial error priority at bits 6:4
// [RULE_03] unimplemented bits read zero, ignore writes
// [RULE_04] priorities reset to level four
// [RULE_05] status bits 11:8 show new cpu level
// [RULE_06] status bits 6:0 show vector minus eight
// [RULE_07] nesting disable stops preemption of handlers
// [RULE_08] equal nonzero priorities allowed; zero never interrupts
// [RULE_09] request needs both flag and enable
// [RULE_10] flag stays until cleared; re-entry follows
// [RULE_11] return restores status low byte, level
// [RULE_12] trap flags stay until cleared
// [RULE_13] cpu level seven blocks all user sources
// [RULE_14] traps never masked by level or disable; code masks a trap not above cpu level or on a full stack
// [RULE_15] timed disable masks levels one to six
// [RULE_16] take only above cpu level, then raise
// [RULE_17] equal levels: lowest vector wins
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "ipc_params.svh"

module ipc_top (
    // clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // register port
    input ipc_pkg::ipc_bus_type bus_i,
    output logic [15:0] rdata_o,
    // source events from same-clock peripherals
    input wire logic [1:0] src_event_i,
    input wire logic [3:0] trap_event_i,
    // core sequencing
    input wire logic irq_ack_i,
    input wire logic ret_i,
    input wire logic timed_irq_disable_start_i,
    input wire logic [13:0] timed_irq_disable_count_i,
    output ipc_pkg::ipc_irq_type irq_o,
    output logic [7:0] status_low_o
);
    import ipc_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [2:0] prio_irq2_q;
    logic [2:0] prio_serr_q;
    logic nest_dis_q;
    logic [3:0] trap_flag_q;
    logic [1:0] flag_q;
    logic [1:0] en_q;
    logic [7:0] srl_q;
    logic ipl3_q;
    logic [2:0] depth_q;
    logic [8:0] stack_q [`IPC_STACK_DEPTH];
    logic [13:0] timed_irq_disable_q;
    logic [10:0] pend_q;
    logic [15:0] rdata_q;
    ipc_irq_type irq_q;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic wr_irq2, wr_serr, wr_ctrl, wr_flag, wr_en, wr_stat;
    logic take, pop;
    logic [3:0] cur_level;
    logic [8:0] top_entry;

    assign wr_irq2 = ce_i && bus_i.wr && bus_i.addr == `IPC_A_IRQ2;
    assign wr_serr = ce_i && bus_i.wr && bus_i.addr == `IPC_A_SERR;
    assign wr_ctrl = ce_i && bus_i.wr && bus_i.addr == `IPC_A_CTRL;
    assign wr_flag = ce_i && bus_i.wr && bus_i.addr == `IPC_A_FLAG;
    assign wr_en = ce_i && bus_i.wr && bus_i.addr == `IPC_A_EN;
    assign wr_stat = ce_i && bus_i.wr && bus_i.addr == `IPC_A_STAT;
    // cpu level is the trap bit above the three level bits of the low byte
    assign cur_level = {ipl3_q, srl_q[7:`IPC_SRL_LVL_LSB]};
    assign take = irq_q.req && irq_ack_i;
    // a return with an empty stack is ignored rather than underflowing
    assign pop = ret_i && !take && depth_q != 3'h0;
    assign top_entry = stack_q[2'(depth_q - 3'h1)];

    // ------------------------------------------------------------
    // priority fields
    // ------------------------------------------------------------
    // only bits 6:4 are stored, the rest of the word is dropped
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            prio_irq2_q <= `IPC_PRIO_RST; // RULE_04
            prio_serr_q <= `IPC_PRIO_RST; // RULE_04
        end else begin
            if (wr_irq2) begin
                prio_irq2_q <= bus_i.wdata[`IPC_PRIO_MSB:`IPC_PRIO_LSB]; // RULE_01
            end
            if (wr_serr) begin
                prio_serr_q <= bus_i.wdata[`IPC_PRIO_MSB:`IPC_PRIO_LSB]; // RULE_02
            end
        end
    end

    // ------------------------------------------------------------
    // flags, enables and control
    // ------------------------------------------------------------
    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            flag_q <= 2'h0;
            en_q <= 2'h0;
            trap_flag_q <= 4'h0;
            nest_dis_q <= 1'b0;
        end else if (ce_i) begin
            flag_q <= (wr_flag ? bus_i.wdata[1:0] : flag_q) | src_event_i; // RULE_10
            trap_flag_q <= (wr_ctrl ? bus_i.wdata[`IPC_TRAP_MSB:`IPC_TRAP_LSB]
                                    : trap_flag_q) | trap_event_i; // RULE_12
            if (wr_en) begin
                en_q <= bus_i.wdata[1:0];
            end
            if (wr_ctrl) begin
                nest_dis_q <= bus_i.wdata[`IPC_NEST_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // timed disable counter
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            timed_irq_disable_q <= 14'h0;
        end else if (ce_i) begin
            if (timed_irq_disable_start_i) begin
                timed_irq_disable_q <= timed_irq_disable_count_i;
            end else if (timed_irq_disable_q != 14'h0) begin
                timed_irq_disable_q <= timed_irq_disable_q - 14'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // candidates and arbitration
    // ------------------------------------------------------------
    ipc_cand_type cand [`IPC_NUM_CAND];
    ipc_cand_type win;
    logic [2:0] uprio [2];
    logic [7:0] uvec [2];

    assign uprio[0] = prio_irq2_q;
    assign uprio[1] = prio_serr_q;
    assign uvec[0] = `IPC_VEC_IRQ2;
    assign uvec[1] = `IPC_VEC_SERR;

    // a full save stack refuses new entries instead of losing a level
    always_comb begin
        logic ok;
        ok = 1'b0;
        for (int t = 0; t < `IPC_NUM_TRAP; t++) begin
            cand[t].vector = `IPC_VEC_TRAP0 + 8'(t);
            cand[t].level = 4'h0;
            // traps ignore disable and nesting; their levels sit above 7
            if (trap_flag_q[t] && depth_q != 3'(`IPC_STACK_DEPTH) &&
                (`IPC_TRAP_LVL_TOP - 4'(t)) > cur_level) begin
                cand[t].level = `IPC_TRAP_LVL_TOP - 4'(t); // RULE_14
            end
        end
        for (int u = 0; u < 2; u++) begin
            ok = flag_q[u] && en_q[u] && uprio[u] != 3'h0; // RULE_09
            if (timed_irq_disable_q != 14'h0 && uprio[u] <= `IPC_TIMED_IRQ_DISABLE_TOP) begin
                ok = 1'b0; // RULE_15
            end
            if (nest_dis_q && depth_q != 3'h0) begin
                ok = 1'b0; // RULE_07
            end
            if ({1'b0, uprio[u]} <= cur_level) begin
                ok = 1'b0; // RULE_16 RULE_13
            end
            if (depth_q == 3'(`IPC_STACK_DEPTH)) begin
                ok = 1'b0;
            end
            cand[`IPC_NUM_TRAP + u].vector = uvec[u];
            cand[`IPC_NUM_TRAP + u].level = ok ? {1'b0, uprio[u]} : 4'h0;
        end
    end

    ipc_pick #(
        .N(`IPC_NUM_CAND)
    ) u_pick (
        .cand_i(cand),
        .win_o(win)
    );

    // ------------------------------------------------------------
    // request to the core
    // ------------------------------------------------------------
    // the request drops for one cycle after a take or a return so that
    // it is re-evaluated against the new cpu level
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            irq_q <= '0;
        end else if (ce_i) begin
            irq_q.req <= win.level != 4'h0 && !take && !ret_i; // RULE_16
            irq_q.vector <= win.vector;
            irq_q.level <= win.level;
        end
    end

    // pending status: winner level and vector offset
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            pend_q <= 11'h0;
        end else if (ce_i) begin
            pend_q[10:7] <= win.level; // RULE_05
            pend_q[6:0] <= win.vector >= `IPC_VEC_BASE ?
                           7'(win.vector - `IPC_VEC_BASE) : 7'h0; // RULE_06
        end
    end

    // ------------------------------------------------------------
    // cpu level and save stack
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            srl_q <= `IPC_SRL_RST;
            ipl3_q <= 1'b0;
            depth_q <= 3'h0;
        end else if (ce_i) begin
            if (take) begin
                depth_q <= depth_q + 3'h1;
                ipl3_q <= irq_q.level[3]; // RULE_16
                srl_q[7:`IPC_SRL_LVL_LSB] <= irq_q.level[2:0];
            end else if (pop) begin
                depth_q <= depth_q - 3'h1;
                {ipl3_q, srl_q} <= top_entry; // RULE_11
            end else if (wr_stat) begin
                srl_q <= bus_i.wdata[7:0]; // RULE_13
            end
        end
    end

    // stack storage, written only on a take
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int s = 0; s < `IPC_STACK_DEPTH; s++) begin
                stack_q[s] <= 9'h0;
            end
        end else if (ce_i && take) begin
            stack_q[depth_q[1:0]] <= {ipl3_q, srl_q}; // RULE_11
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // unmapped indices and idle cycles return zero
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            rdata_q <= 16'h0;
        end else if (ce_i) begin
            rdata_q <= 16'h0;
            if (bus_i.rd) begin
                unique case (bus_i.addr)
                    `IPC_A_IRQ2: rdata_q[`IPC_PRIO_MSB:`IPC_PRIO_LSB] <= prio_irq2_q; // RULE_03
                    `IPC_A_SERR: rdata_q[`IPC_PRIO_MSB:`IPC_PRIO_LSB] <= prio_serr_q; // RULE_03
                    `IPC_A_PEND: rdata_q <= {4'h0, pend_q[10:7], 1'b0, pend_q[6:0]};
                    `IPC_A_CTRL: rdata_q <= {nest_dis_q, 10'h0, trap_flag_q, 1'b0};
                    `IPC_A_FLAG: rdata_q <= {14'h0, flag_q};
                    `IPC_A_EN: rdata_q <= {14'h0, en_q};
                    `IPC_A_STAT: rdata_q <= {7'h0, ipl3_q, srl_q};
                    default: rdata_q <= 16'h0;
                endcase
            end
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign status_low_o = srl_q;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_take;
        ce_i && irq_q.req && irq_ack_i;
    endsequence
    sequence s_pop;
        ce_i && ret_i && !irq_ack_i && depth_q != 3'h0;
    endsequence

    property p_prio_wr;
        wr_irq2 |=> prio_irq2_q == $past(bus_i.wdata[6:4]);
    endproperty
    a_prio_wr: assert property (p_prio_wr) else $error("irq2 priority not stored"); // RULE_01
    property p_unimpl;
        ce_i && bus_i.rd && bus_i.addr inside {`IPC_A_IRQ2, `IPC_A_SERR}
            |=> rdata_q[15:7] == 9'h0 && rdata_q[3:0] == 4'h0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bits not zero"); // RULE_03
    property p_pend_rd;
        ce_i && bus_i.rd && bus_i.addr == `IPC_A_PEND
            |=> rdata_q[11:8] == $past(pend_q[10:7]) && rdata_q[15:12] == 4'h0;
    endproperty
    a_pend_rd: assert property (p_pend_rd) else $error("pending status read wrong"); // RULE_05
    property p_raise;
        s_take |=> cur_level == $past(irq_q.level) && !irq_q.req;
    endproperty
    a_raise: assert property (p_raise) else $error("cpu level not raised on take"); // RULE_16
    property p_unstack;
        s_pop |=> {ipl3_q, srl_q} == $past(top_entry);
    endproperty
    a_unstack: assert property (p_unstack) else $error("return did not restore"); // RULE_11
    property p_timed_irq_disable;
        ce_i && timed_irq_disable_q != 14'h0 |=> !(irq_q.req && irq_q.level inside {[1:6]});
    endproperty
    a_timed_irq_disable: assert property (p_timed_irq_disable) else $error("timed disable let low level"); // RULE_15
    property p_lvl7;
        ce_i && cur_level >= `IPC_USER_MAX |=> !(irq_q.req && irq_q.level <= 4'h7);
    endproperty
    a_lvl7: assert property (p_lvl7) else $error("user source passed level 7"); // RULE_13
    property p_trap;
        ce_i && trap_flag_q != 4'h0 && cur_level <= 4'h7 && depth_q == 3'h0 &&
            !irq_ack_i && !ret_i |=> irq_q.req && irq_q.level >= 4'h8;
    endproperty
    a_trap: assert property (p_trap) else $error("trap was masked"); // RULE_14
    property p_nest;
        ce_i && nest_dis_q && depth_q != 3'h0 |=> !(irq_q.req && irq_q.level <= 4'h7);
    endproperty
    a_nest: assert property (p_nest) else $error("nested user interrupt taken"); // RULE_07
    property p_flag_hold;
        ce_i && !wr_flag |=> (flag_q & $past(flag_q)) == $past(flag_q);
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost"); // RULE_10

endmodule // ipc_top

// *** dv/ipc_core_model.sv ***
// core-side model: takes offered requests and issues returns
`timescale 1ns/1ps

module ipc_core_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // bench control
    input wire logic ack_en_i,
    input wire logic slow_i,
    input wire logic ret_req_i,
    // controller side
    input ipc_pkg::ipc_irq_type irq_i,
    output logic irq_ack_o,
    output logic ret_o,
    output logic [15:0] take_cnt_o,
    output ipc_pkg::ipc_irq_type last_o
);
    import ipc_pkg::*;
    logic [1:0] wait_q;

    // ----------------------------------------
    // entry side
    // ----------------------------------------
    // ack is a one-cycle pulse after 0 or 3 waits, so one offer is taken once
    always_ff @(posedge clock_i) begin
        if (!rst_n_i || irq_ack_o || !(ack_en_i && irq_i.req)) begin
            irq_ack_o <= 1'b0;
            wait_q <= 2'h0;
        end else if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
            irq_ack_o <= 1'b1;
        end else begin
            wait_q <= wait_q + 2'h1;
        end
    end

    // record what was taken; counted only while the offer stands
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            take_cnt_o <= 16'h0000;
            last_o <= '0;
        end else if (irq_ack_o && irq_i.req) begin
            take_cnt_o <= take_cnt_o + 16'h0001;
            last_o <= irq_i;
        end
    end

    // ----------------------------------------
    // exit side
    // ----------------------------------------
    // bench asks for a return only while no ack is pending
    always_ff @(posedge clock_i) begin
        ret_o <= rst_n_i && ret_req_i;
    end
endmodule // ipc_core_model

// *** dv/testbench.sv ***
// self-checking bench for the interrupt priority control block
`timescale 1ns/1ps
`include "ipc_params.svh"

module testbench;
    import ipc_pkg::*;
    logic clock_i;
    logic rst_n_i;
    ipc_bus_type bus;
    logic [15:0] rdata;
    logic [1:0] src_ev;
    logic [3:0] trap_ev;
    logic ack, ret, timed_irq_disable_go, ack_en, ret_req, slow, ce;
    logic [13:0] timed_irq_disable_n;
    logic [15:0] takes;
    ipc_irq_type irq, last;
    logic [7:0] status_low_byte;
    int failures;
    int n_checks;

    ipc_top DUT (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce), .bus_i(bus),
        .rdata_o(rdata), .src_event_i(src_ev), .trap_event_i(trap_ev), .irq_ack_i(ack),
        .ret_i(ret), .timed_irq_disable_start_i(timed_irq_disable_go), .timed_irq_disable_count_i(timed_irq_disable_n), .irq_o(irq),
        .status_low_o(status_low_byte));
    ipc_core_model core (.clock_i(clock_i), .rst_n_i(rst_n_i), .ack_en_i(ack_en),
        .slow_i(slow), .ret_req_i(ret_req), .irq_i(irq), .irq_ack_o(ack), .ret_o(ret),
        .take_cnt_o(takes), .last_o(last));

    // 100 ns clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock_i);
        bus.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock_i);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clock_i);
        bus.rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask

    task automatic ev(input logic [1:0] s, input logic [3:0] t);
        @(posedge clock_i);
        src_ev <= s;
        trap_ev <= t;
        @(posedge clock_i);
        src_ev <= 2'b00;
        trap_ev <= 4'h0;
    endtask

    task automatic req_is(input logic r, input logic [7:0] v, input logic [3:0] l);
        repeat (3) @(posedge clock_i);
        #1 chk("req", {15'h0000, r}, {15'h0000, irq.req});
        if (r) begin
            chk("vector", {8'h00, v}, {8'h00, irq.vector});
            chk("level", {12'h000, l}, {12'h000, irq.level});
        end
    endtask

    // ack is dropped right after the take so a later offer is not swallowed
    task automatic take(input logic [7:0] v, input logic [3:0] l);
        logic [15:0] old;
        old = takes;
        @(posedge clock_i);
        ack_en <= 1'b1;
        for (int i = 0; i < 30 && takes === old; i++) @(posedge clock_i);
        ack_en <= 1'b0;
        @(posedge clock_i);
        #1 chk("takes", old + 16'h0001, takes);
        chk("taken vector", {8'h00, v}, {8'h00, last.vector});
        chk("taken level", {12'h000, l}, {12'h000, last.level});
        chk("cpu level", {13'h0000, l[2:0]}, {13'h0000, status_low_byte[7:5]});
    endtask

    task automatic no_take(input int n);
        logic [15:0] old;
        old = takes;
        @(posedge clock_i);
        ack_en <= 1'b1;
        repeat (n) @(posedge clock_i);
        ack_en <= 1'b0;
        #1 chk("no take", old, takes);
    endtask

    task automatic do_ret;
        @(posedge clock_i);
        ret_req <= 1'b1;
        @(posedge clock_i);
        ret_req <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd(`IPC_A_IRQ2, 16'h0040);
        rd(`IPC_A_SERR, 16'h0040);
        rd(`IPC_A_PEND, 16'h0000);
        wr(`IPC_A_IRQ2, 16'hffff);
        rd(`IPC_A_IRQ2, 16'h0070);
        wr(`IPC_A_SERR, 16'hffff);
        rd(`IPC_A_SERR, 16'h0070);
        wr(`IPC_A_SERR, 16'h0010);
        rd(`IPC_A_SERR, 16'h0010);
        wr(`IPC_A_PEND, 16'hffff);
        rd(`IPC_A_PEND, 16'h0000);
        wr(4'hf, 16'hffff);
        rd(4'hf, 16'h0000);
    endtask

    // flag and enable gating, entry, return and re-entry
    task automatic t_entry;
        wr(`IPC_A_IRQ2, 16'h0040);
        wr(`IPC_A_SERR, 16'h0000);
        wr(`IPC_A_FLAG, 16'h0000);
        ev(2'b01, 4'h0);
        req_is(1'b0, 8'h00, 4'h0);
        rd(`IPC_A_FLAG, 16'h0001);
        wr(`IPC_A_EN, 16'h0001);
        req_is(1'b1, 8'h25, 4'h4);
        rd(`IPC_A_PEND, 16'h041d);
        wr(`IPC_A_STAT, 16'h0005);
        take(8'h25, 4'h4);
        do_ret;
        chk("status", 16'h0005, {8'h00, status_low_byte});
        @(posedge clock_i);
        slow <= 1'b1;
        take(8'h25, 4'h4);
        slow <= 1'b0;
        wr(`IPC_A_FLAG, 16'h0000);
        do_ret;
        no_take(10);
        wr(`IPC_A_STAT, 16'h0000);
    endtask

    // arbitration, cpu level masking, traps
    task automatic t_arb;
        wr(`IPC_A_SERR, 16'h0040);
        wr(`IPC_A_EN, 16'h0003);
        ev(2'b11, 4'h0);
        req_is(1'b1, 8'h25, 4'h4);
        wr(`IPC_A_SERR, 16'h0050);
        req_is(1'b1, 8'h49, 4'h5);
        wr(`IPC_A_IRQ2, 16'h0000);
        wr(`IPC_A_SERR, 16'h0000);
        req_is(1'b0, 8'h00, 4'h0);
        wr(`IPC_A_IRQ2, 16'h0070);
        wr(`IPC_A_STAT, 16'h00e0);
        req_is(1'b0, 8'h00, 4'h0);
        wr(`IPC_A_STAT, 16'h00c0);
        req_is(1'b1, 8'h25, 4'h7);
        wr(`IPC_A_STAT, 16'h00e0);
        ev(2'b00, 4'h1);
        req_is(1'b1, 8'h02, 4'he);
        take(8'h02, 4'he);
        rd(`IPC_A_STAT, 16'h01c0);
        rd(`IPC_A_CTRL, 16'h0002);
        do_ret;
        take(8'h02, 4'he);
        wr(`IPC_A_CTRL, 16'h0000);
        do_ret;
        no_take(10);
        wr(`IPC_A_FLAG, 16'h0000);
        wr(`IPC_A_STAT, 16'h0000);
    endtask

    // timed disable stops level six but not seven
    task automatic t_timed_irq_disable;
        wr(`IPC_A_IRQ2, 16'h0060);
        ev(2'b01, 4'h0);
        @(posedge clock_i);
        timed_irq_disable_n <= 14'd40;
        timed_irq_disable_go <= 1'b1;
        @(posedge clock_i);
        timed_irq_disable_go <= 1'b0;
        req_is(1'b0, 8'h00, 4'h0);
        wr(`IPC_A_SERR, 16'h0070);
        ev(2'b10, 4'h0);
        req_is(1'b1, 8'h49, 4'h7);
        wr(`IPC_A_SERR, 16'h0000);
        req_is(1'b0, 8'h00, 4'h0);
        repeat (40) @(posedge clock_i);
        req_is(1'b1, 8'h25, 4'h6);
        wr(`IPC_A_FLAG, 16'h0000);
    endtask

    // nesting disabled, then enabled for contrast
    task automatic t_nest;
        wr(`IPC_A_CTRL, 16'h8000);
        wr(`IPC_A_IRQ2, 16'h0040);
        wr(`IPC_A_SERR, 16'h0070);
        ev(2'b01, 4'h0);
        take(8'h25, 4'h4);
        ev(2'b10, 4'h0);
        no_take(15);
        wr(`IPC_A_FLAG, 16'h0002);
        do_ret;
        take(8'h49, 4'h7);
        wr(`IPC_A_FLAG, 16'h0000);
        do_ret;
        wr(`IPC_A_CTRL, 16'h0000);
        ev(2'b01, 4'h0);
        take(8'h25, 4'h4);
        ev(2'b10, 4'h0);
        take(8'h49, 4'h7);
        wr(`IPC_A_FLAG, 16'h0000);
        do_ret;
        do_ret;
    endtask

    // clock enable low must drop both a register write and a source event
    task automatic t_ce;
        @(posedge clock_i);
        ce <= 1'b0;
        wr(`IPC_A_IRQ2, 16'h0010);
        ev(2'b01, 4'h0);
        @(posedge clock_i);
        ce <= 1'b1;
        rd(`IPC_A_IRQ2, 16'h0040);
        rd(`IPC_A_FLAG, 16'h0000);
    endtask

    // ----------------------------------------
    // verdict, watchdog and main sequence
    // ----------------------------------------
    task automatic finish_test;
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock_i);
        failures++;
        finish_test;
    end

    initial begin
        failures = 0;
        n_checks = 0;
        bus = '0;
        src_ev = 2'b00;
        trap_ev = 4'h0;
        timed_irq_disable_go = 1'b0;
        timed_irq_disable_n = 14'd0;
        ack_en = 1'b0;
        ret_req = 1'b0;
        slow = 1'b0;
        ce = 1'b1;
        rst_n_i = 1'b0;
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_entry;
        t_arb;
        t_timed_irq_disable;
        t_nest;
        t_ce;
        finish_test;
    end
endmodule // testbench
